// ===== irq_pkg.sv
package irq_pkg;
	// register bus shape
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [2:0] ADDR_RESET_CAUSE   = 3'h0;
	localparam logic [2:0] ADDR_CTRL_FIRST    = 3'h1;
	localparam logic [2:0] ADDR_CTRL_SECOND   = 3'h2;
	localparam logic [2:0] ADDR_CTRL_THIRD    = 3'h3;
	localparam logic [2:0] ADDR_TIMER_LOW     = 3'h4;
	localparam logic [2:0] ADDR_TIMER_HIGH    = 3'h5;
	localparam logic [2:0] ADDR_TIMER_CONFIG  = 3'h6;

	// reset_cause_control fields
	localparam int RC_PRIORITY_LEVELS_ENABLE  = 7;
	localparam int RC_SOFTWARE_BROWNOUT_EN    = 6;
	localparam int RC_UNIMPLEMENTED           = 5;
	localparam int RC_RESET_INSTRUCTION_FLAG  = 4;
	localparam int RC_WATCHDOG_EXPIRED_FLAG   = 3;
	localparam int RC_POWER_DOWN_FLAG         = 2;
	localparam int RC_POWER_ON_FLAG           = 1;
	localparam int RC_BROWNOUT_RESET_FLAG     = 0;
	localparam logic [7:0] RC_RESET_VALUE     = 8'h5C;
	localparam logic [7:0] RC_WRITE_MASK      = 8'hD3;

	// irq_control_first fields
	localparam int F1_GLOBAL_IRQ_ENABLE       = 7;
	localparam int F1_LOW_GLOBAL_ENABLE       = 6;
	localparam int F1_TIMER_OVERFLOW_ENABLE   = 5;
	localparam int F1_EXT0_ENABLE             = 4;
	localparam int F1_PORT_CHANGE_ENABLE      = 3;
	localparam int F1_TIMER_OVERFLOW_FLAG     = 2;
	localparam int F1_EXT0_FLAG               = 1;
	localparam int F1_PORT_CHANGE_FLAG        = 0;

	// irq_control_second fields
	localparam int F2_EDGE_SELECT_LSB         = 3;
	localparam int F2_TIMER_OVERFLOW_PRIORITY = 2;
	localparam int F2_EXT3_PRIORITY           = 1;
	localparam int F2_PORT_CHANGE_PRIORITY    = 0;

	// irq_control_third fields
	localparam int F3_EXT2_PRIORITY           = 7;
	localparam int F3_EXT1_PRIORITY           = 6;
	localparam int F3_ENABLE_LSB              = 3;
	localparam int F3_FLAG_LSB                = 0;

	// timer configuration fields
	localparam int TC_RUN                     = 0;
	localparam int TC_SIXTEEN_BIT             = 1;

	localparam logic [7:0]  CTRL_RESET_VALUE  = 8'h00;
	localparam logic [7:0]  TCFG_RESET_VALUE  = 8'h00;
	localparam logic [15:0] TIMER_RESET_VALUE = 16'h0000;
	localparam logic [7:0]  COUNT8_MAX        = 8'hFF;
	localparam logic [15:0] COUNT16_MAX       = 16'hFFFF;

	localparam int PC_W        = 21;
	localparam int STACK_DEPTH = 31;

	typedef struct packed {
		logic reset_instr;
		logic watchdog_expired;
		logic sleep_entry;
		logic watchdog_cleared;
		logic power_on;
		logic brownout;
	} cause_events_t;

	typedef struct packed {
		logic [7:0] working_accumulator;
		logic [7:0] status;
		logic [7:0] bank_select_reg;
	} context_t;

	function automatic logic [7:0] merge_bits(input logic [7:0] old_v,
		input logic [7:0] new_v, input logic [7:0] mask);
		merge_bits = (new_v & mask) | (old_v & ~mask);
	endfunction : merge_bits
endpackage : irq_pkg

// ===== pin_edge_sync.sv
module pin_edge_sync #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input  wire logic             clock_in,
	input  wire logic             reset_in,
	// pins
	input  wire logic [WIDTH-1:0] pins_in,
	// detected events
	output logic      [WIDTH-1:0] rise_out,
	output logic      [WIDTH-1:0] fall_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
		logic [WIDTH-1:0] prev;
		logic [1:0]       armed;
	} sync_state_t;

	sync_state_t s_r;
	sync_state_t s_nxt;

	always_comb
	begin
		s_nxt       = s_r;
		s_nxt.meta  = pins_in;
		s_nxt.sync  = s_r.meta;
		s_nxt.prev  = s_r.sync;
		// hold off until prev holds a real sample, or a high pin fakes a rise
		if (s_r.armed != 2'h3)
			s_nxt.armed = s_r.armed + 2'h1;
	end

	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	always_comb
	begin
		rise_out = (s_r.armed == 2'h3) ? (s_r.sync & ~s_r.prev) : '0;
		fall_out = (s_r.armed == 2'h3) ? (~s_r.sync & s_r.prev) : '0;
	end
endmodule : pin_edge_sync

// ===== return_stack.sv
module return_stack #(
	parameter int WIDTH = 21,
	parameter int DEPTH = 31
) (
	// clock and reset
	input  wire logic             clock_in,
	input  wire logic             reset_in,
	// push and pop
	input  wire logic             push_in,
	input  wire logic [WIDTH-1:0] push_data_in,
	input  wire logic             pop_in,
	// stack view
	output logic      [WIDTH-1:0] top_out,
	output logic                  full_out,
	output logic                  empty_out
);
	localparam int PTR_W = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [PTR_W-1:0] ptr;
		logic [WIDTH-1:0] top;
	} stack_state_t;

	stack_state_t     s_r;
	stack_state_t     s_nxt;
	logic [WIDTH-1:0] mem [DEPTH];

	always_comb
	begin
		s_nxt = s_r;
		// a push onto a full stack is dropped; the oldest entries are kept
		if (push_in && s_r.ptr != PTR_W'(DEPTH))
		begin
			s_nxt.ptr = s_r.ptr + PTR_W'(1);
			s_nxt.top = push_data_in;
		end
		else if (pop_in && !push_in && s_r.ptr != '0)
		begin
			s_nxt.ptr = s_r.ptr - PTR_W'(1);
			s_nxt.top = (s_r.ptr > PTR_W'(1)) ? mem[s_r.ptr - PTR_W'(2)] : '0;
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			s_r <= '0;
		else
			s_r <= s_nxt;
		if (!reset_in && push_in && s_r.ptr != PTR_W'(DEPTH))
			mem[s_r.ptr] <= push_data_in;
	end

	assign top_out   = s_r.top;
	assign full_out  = (s_r.ptr == PTR_W'(DEPTH));
	assign empty_out = (s_r.ptr == '0);
endmodule : return_stack

// ===== irq_source_priority_logic.sv
// Function
// - priority enable bit selects two-level priority
// - reset control holds reset and wake causes
// - bit five of reset control reads zero
// - edge select: one rising, zero falling
// - qualifying pin edge sets its flag
// - cleared enable blocks the source, flag still sets
// - enabled external interrupt wakes the processor
// - vector after wake only when globally enabled
// - external one to three priority bits
// - external zero is always high priority
// - eight-bit timer wrap sets overflow flag
// - sixteen-bit timer wrap sets overflow flag
// - timer overflow enable and priority bits
// - upper port pin change sets change flag
// - port change enable and priority bits
// - entry pushes return address onto stack
// - entry copies working, status, bank into shadow
//
// Added by the designer: the register offsets and the plain strobed port.
module irq_source_priority_logic #(
	parameter int STACK_DEPTH = irq_pkg::STACK_DEPTH
) (
	// clock and reset
	input  wire logic                           clock_in,
	input  wire logic                           reset_in,
	// register port
	input  wire logic [irq_pkg::ADDR_W-1:0]     addr_in,
	input  wire logic [irq_pkg::DATA_W-1:0]     wdata_in,
	input  wire logic                           wr_in,
	input  wire logic                           rd_in,
	output logic      [irq_pkg::DATA_W-1:0]     rdata_out,
	// pins
	input  wire logic [3:0]                     ext_irq_pins_in,
	input  wire logic [3:0]                     port_upper_pins_in,
	// timer and reset-cause events
	input  wire logic                           timer_tick_in,
	input  wire irq_pkg::cause_events_t         cause_events_in,
	// core interrupt handshake
	input  wire logic                           irq_entry_in,
	input  wire logic                           irq_entry_low_in,
	input  wire logic                           irq_return_in,
	input  wire logic [irq_pkg::PC_W-1:0]       return_pc_in,
	input  wire irq_pkg::context_t              context_in,
	output logic                                high_irq_req_out,
	output logic                                low_irq_req_out,
	output logic                                wake_out,
	// saved context
	output logic      [irq_pkg::PC_W-1:0]       stack_top_out,
	output logic                                stack_full_out,
	output logic                                stack_empty_out,
	output irq_pkg::context_t                   shadow_out
);
	typedef struct packed {
		logic [7:0]        reset_cause_control;
		logic [7:0]        first;
		logic [7:0]        second;
		logic [7:0]        third;
		logic [15:0]       count;
		logic [7:0]        tcfg;
		logic [7:0]        rdata;
		irq_pkg::context_t shadow;
	} irq_state_t;

	irq_state_t s_r;
	irq_state_t s_nxt;
	logic [3:0] ext_rise;
	logic [3:0] ext_fall;
	logic [3:0] port_rise;
	logic [3:0] port_fall;
	logic [3:0] edge_sel;
	logic [3:0] ext_hit;
	logic [3:0] ext_pend;
	logic       tmr_pend;
	logic       rb_pend;
	logic       high_any;
	logic       low_any;
	logic       prio_mode;
	logic       gie_high;
	logic       gie_low;

	pin_edge_sync #(
		.WIDTH (4)
	) ext_sync (
		.clock_in (clock_in),
		.reset_in (reset_in),
		.pins_in  (ext_irq_pins_in),
		.rise_out (ext_rise),
		.fall_out (ext_fall)
	);

	pin_edge_sync #(
		.WIDTH (4)
	) port_sync (
		.clock_in (clock_in),
		.reset_in (reset_in),
		.pins_in  (port_upper_pins_in),
		.rise_out (port_rise),
		.fall_out (port_fall)
	);

	return_stack #(
		.WIDTH (irq_pkg::PC_W),
		.DEPTH (STACK_DEPTH)
	) pc_stack (
		.clock_in     (clock_in),
		.reset_in     (reset_in),
		.push_in      (irq_entry_in),
		.push_data_in (return_pc_in),
		.pop_in       (irq_return_in),
		.top_out      (stack_top_out),
		.full_out     (stack_full_out),
		.empty_out    (stack_empty_out)
	);

	// edge selects for sources 0..3 sit high to low in the second register
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			edge_sel[i] = s_r.second[irq_pkg::F2_EDGE_SELECT_LSB + 3 - i];
		for (int i = 0; i < 4; i++)
			ext_hit[i] = edge_sel[i] ? ext_rise[i] : ext_fall[i];
	end

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.rdata = '0;
		if (rd_in)
		begin
			unique case (addr_in)
				irq_pkg::ADDR_RESET_CAUSE:  s_nxt.rdata = s_r.reset_cause_control;
				irq_pkg::ADDR_CTRL_FIRST:   s_nxt.rdata = s_r.first;
				irq_pkg::ADDR_CTRL_SECOND:  s_nxt.rdata = s_r.second;
				irq_pkg::ADDR_CTRL_THIRD:   s_nxt.rdata = s_r.third;
				irq_pkg::ADDR_TIMER_LOW:    s_nxt.rdata = s_r.count[7:0];
				irq_pkg::ADDR_TIMER_HIGH:   s_nxt.rdata = s_r.count[15:8];
				irq_pkg::ADDR_TIMER_CONFIG: s_nxt.rdata = s_r.tcfg;
				default:                    s_nxt.rdata = '0;
			endcase
		end
		if (wr_in)
		begin
			unique case (addr_in)
				irq_pkg::ADDR_RESET_CAUSE:
					s_nxt.reset_cause_control = irq_pkg::merge_bits(s_r.reset_cause_control, wdata_in,
						irq_pkg::RC_WRITE_MASK);
				irq_pkg::ADDR_CTRL_FIRST:   s_nxt.first = wdata_in;
				irq_pkg::ADDR_CTRL_SECOND:  s_nxt.second = wdata_in;
				irq_pkg::ADDR_CTRL_THIRD:   s_nxt.third = wdata_in;
				irq_pkg::ADDR_TIMER_LOW:    s_nxt.count[7:0] = wdata_in;
				irq_pkg::ADDR_TIMER_HIGH:   s_nxt.count[15:8] = wdata_in;
				irq_pkg::ADDR_TIMER_CONFIG: s_nxt.tcfg = wdata_in;
				default:                    s_nxt.rdata = s_nxt.rdata;
			endcase
		end

		// hardware cause updates come after the write so they win
		if (cause_events_in.watchdog_cleared)
		begin
			s_nxt.reset_cause_control[irq_pkg::RC_WATCHDOG_EXPIRED_FLAG] = 1'b1;
			s_nxt.reset_cause_control[irq_pkg::RC_POWER_DOWN_FLAG]       = 1'b1;
		end
		if (cause_events_in.reset_instr)
			s_nxt.reset_cause_control[irq_pkg::RC_RESET_INSTRUCTION_FLAG] = 1'b0;
		if (cause_events_in.watchdog_expired)
			s_nxt.reset_cause_control[irq_pkg::RC_WATCHDOG_EXPIRED_FLAG] = 1'b0;
		if (cause_events_in.sleep_entry)
			s_nxt.reset_cause_control[irq_pkg::RC_POWER_DOWN_FLAG] = 1'b0;
		if (cause_events_in.power_on)
			s_nxt.reset_cause_control[irq_pkg::RC_POWER_ON_FLAG] = 1'b0;
		if (cause_events_in.brownout)
			s_nxt.reset_cause_control[irq_pkg::RC_BROWNOUT_RESET_FLAG] = 1'b0;
		s_nxt.reset_cause_control[irq_pkg::RC_UNIMPLEMENTED] = 1'b0;

		// timer; a software write to the count takes that cycle's tick
		if (s_r.tcfg[irq_pkg::TC_RUN] && timer_tick_in && !(wr_in &&
			(addr_in == irq_pkg::ADDR_TIMER_LOW || addr_in == irq_pkg::ADDR_TIMER_HIGH)))
		begin
			if (s_r.tcfg[irq_pkg::TC_SIXTEEN_BIT])
			begin
				s_nxt.count = s_r.count + 16'h0001;
				if (s_r.count == irq_pkg::COUNT16_MAX)
					s_nxt.first[irq_pkg::F1_TIMER_OVERFLOW_FLAG] = 1'b1;
			end
			else
			begin
				s_nxt.count[7:0] = s_r.count[7:0] + 8'h01;
				if (s_r.count[7:0] == irq_pkg::COUNT8_MAX)
					s_nxt.first[irq_pkg::F1_TIMER_OVERFLOW_FLAG] = 1'b1;
			end
		end

		// flags set regardless of enable; set beats a same-cycle clear
		if (ext_hit[0])
			s_nxt.first[irq_pkg::F1_EXT0_FLAG] = 1'b1;
		for (int i = 1; i < 4; i++)
			if (ext_hit[i])
				s_nxt.third[irq_pkg::F3_FLAG_LSB + i - 1] = 1'b1;
		if (|(port_rise | port_fall))
			s_nxt.first[irq_pkg::F1_PORT_CHANGE_FLAG] = 1'b1;

		// entry drops the enable of the level taken, return raises it again
		if (irq_entry_in)
		begin
			s_nxt.shadow = context_in;
			if (prio_mode && irq_entry_low_in)
				s_nxt.first[irq_pkg::F1_LOW_GLOBAL_ENABLE] = 1'b0;
			else
				s_nxt.first[irq_pkg::F1_GLOBAL_IRQ_ENABLE] = 1'b0;
		end
		else if (irq_return_in)
		begin
			if (prio_mode && gie_high)
				s_nxt.first[irq_pkg::F1_LOW_GLOBAL_ENABLE] = 1'b1;
			else
				s_nxt.first[irq_pkg::F1_GLOBAL_IRQ_ENABLE] = 1'b1;
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (reset_in)
		begin
			s_r.reset_cause_control   <= irq_pkg::RC_RESET_VALUE;
			s_r.first  <= irq_pkg::CTRL_RESET_VALUE;
			s_r.second <= irq_pkg::CTRL_RESET_VALUE;
			s_r.third  <= irq_pkg::CTRL_RESET_VALUE;
			s_r.count  <= irq_pkg::TIMER_RESET_VALUE;
			s_r.tcfg   <= irq_pkg::TCFG_RESET_VALUE;
			s_r.rdata  <= '0;
			s_r.shadow <= '0;
		end
		else
			s_r <= s_nxt;
	end

	// pending means flag and enable; the handler owns flag clearing
	always_comb
	begin
		ext_pend[0] = s_r.first[irq_pkg::F1_EXT0_FLAG] &
			s_r.first[irq_pkg::F1_EXT0_ENABLE];
		for (int i = 1; i < 4; i++)
			ext_pend[i] = s_r.third[irq_pkg::F3_FLAG_LSB + i - 1] &
				s_r.third[irq_pkg::F3_ENABLE_LSB + i - 1];
		tmr_pend = s_r.first[irq_pkg::F1_TIMER_OVERFLOW_FLAG] &
			s_r.first[irq_pkg::F1_TIMER_OVERFLOW_ENABLE];
		rb_pend  = s_r.first[irq_pkg::F1_PORT_CHANGE_FLAG] &
			s_r.first[irq_pkg::F1_PORT_CHANGE_ENABLE];
	end

	always_comb
	begin
		prio_mode = s_r.reset_cause_control[irq_pkg::RC_PRIORITY_LEVELS_ENABLE];
		gie_high  = s_r.first[irq_pkg::F1_GLOBAL_IRQ_ENABLE];
		gie_low   = s_r.first[irq_pkg::F1_LOW_GLOBAL_ENABLE];
		high_any  = ext_pend[0]
			| (ext_pend[1] & s_r.third[irq_pkg::F3_EXT1_PRIORITY])
			| (ext_pend[2] & s_r.third[irq_pkg::F3_EXT2_PRIORITY])
			| (ext_pend[3] & s_r.second[irq_pkg::F2_EXT3_PRIORITY])
			| (tmr_pend & s_r.second[irq_pkg::F2_TIMER_OVERFLOW_PRIORITY])
			| (rb_pend & s_r.second[irq_pkg::F2_PORT_CHANGE_PRIORITY]);
		low_any   = (ext_pend[1] & ~s_r.third[irq_pkg::F3_EXT1_PRIORITY])
			| (ext_pend[2] & ~s_r.third[irq_pkg::F3_EXT2_PRIORITY])
			| (ext_pend[3] & ~s_r.second[irq_pkg::F2_EXT3_PRIORITY])
			| (tmr_pend & ~s_r.second[irq_pkg::F2_TIMER_OVERFLOW_PRIORITY])
			| (rb_pend & ~s_r.second[irq_pkg::F2_PORT_CHANGE_PRIORITY]);
		if (prio_mode)
		begin
			high_irq_req_out = gie_high & high_any;
			low_irq_req_out  = gie_high & gie_low & low_any & ~high_any;
		end
		else
		begin
			// single level: every source vectors through the one request
			high_irq_req_out = gie_high & (high_any | low_any);
			low_irq_req_out  = 1'b0;
		end
		wake_out = (|ext_pend) | tmr_pend | rb_pend;
	end

	assign rdata_out  = s_r.rdata;
	assign shadow_out = s_r.shadow;
endmodule : irq_source_priority_logic

// ===== irq_checker.sv
module irq_checker (
	// clock and reset
	input  wire logic              clock_in,
	input  wire logic              reset_in,
	// register port
	input  wire logic [2:0]        addr_in,
	input  wire logic [7:0]        wdata_in,
	input  wire logic              wr_in,
	input  wire logic              rd_in,
	input  wire logic [7:0]        rdata_out,
	// core side
	input  wire logic              irq_entry_in,
	input  wire logic [20:0]       return_pc_in,
	input  wire irq_pkg::context_t context_in,
	input  wire logic              high_irq_req_out,
	input  wire logic              low_irq_req_out,
	input  wire logic              wake_out,
	input  wire logic [20:0]       stack_top_out,
	input  wire logic              stack_full_out,
	input  wire logic              stack_empty_out,
	input  wire irq_pkg::context_t shadow_out
);
	logic prio_r;
	// mirror of the priority mode bit, kept from the write strobes
	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			prio_r <= 1'b0;
		else if (wr_in && addr_in == irq_pkg::ADDR_RESET_CAUSE)
			prio_r <= wdata_in[irq_pkg::RC_PRIORITY_LEVELS_ENABLE];
	end
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (reset_in);
	a_unimpl_bit_zero: assert property (rd_in && addr_in == 3'h0 |=> !rdata_out[5])
		else $error("reset cause bit five read as one");
	a_push_return_pc: assert property (irq_entry_in && !stack_full_out |=>
		stack_top_out == $past(return_pc_in) && !stack_empty_out)
		else $error("return address not on stack top");
	a_shadow_copy: assert property (irq_entry_in |=> shadow_out == $past(context_in))
		else $error("shadow does not hold entry context");
	a_single_level: assert property (!prio_r |-> !low_irq_req_out)
		else $error("low request outside priority mode");
	a_low_yields_high: assert property (low_irq_req_out |-> !high_irq_req_out)
		else $error("low request beside high request");
	a_request_wakes: assert property (high_irq_req_out || low_irq_req_out |-> wake_out)
		else $error("request without wake");
	a_entry_masks_req: assert property (irq_entry_in && !prio_r && !wr_in |=>
		!high_irq_req_out[*2])
		else $error("request stays after single level entry");
	a_reset_quiet: assert property ($fell(reset_in) |->
		!high_irq_req_out && !low_irq_req_out && !wake_out && stack_empty_out)
		else $error("outputs busy after reset");
	c_high_entry: cover property (high_irq_req_out && irq_entry_in);
	c_low_req: cover property (low_irq_req_out);
	c_wake_only: cover property (wake_out && !high_irq_req_out && !low_irq_req_out);
endmodule : irq_checker

bind irq_source_priority_logic irq_checker i_chk (.clock_in, .reset_in, .addr_in, .wdata_in,
	.wr_in, .rd_in, .rdata_out, .irq_entry_in, .return_pc_in, .context_in,
	.high_irq_req_out, .low_irq_req_out, .wake_out, .stack_top_out, .stack_full_out,
	.stack_empty_out, .shadow_out);

// ===== core_model.sv
module core_model (
	// clock and reset
	input  wire logic               clock_in,
	input  wire logic               reset_in,
	// requests and test control
	input  wire logic               high_req_in,
	input  wire logic               low_req_in,
	input  wire logic               accept_in,
	input  wire logic               return_cmd_in,
	input  wire logic [3:0]         delay_in,
	// handshake to the block
	output logic                    entry_out,
	output logic                    entry_low_out,
	output logic                    return_out,
	output logic [20:0]             pc_out,
	output irq_pkg::context_t       ctx_out
);
	logic       busy_r;
	logic [3:0] wait_r;
	// pc runs every cycle so a late capture shows up as a wrong value
	assign ctx_out = {pc_out[7:0], ~pc_out[7:0], 8'hA5};
	always_ff @(posedge clock_in)
	begin
		entry_out <= 1'b0;
		return_out <= 1'b0;
		entry_low_out <= !high_req_in;
		pc_out <= pc_out + 21'h000001;
		if (reset_in)
		begin
			busy_r <= 1'b0;
			wait_r <= 4'h0;
			pc_out <= 21'h012340;
		end
		else if (!busy_r && accept_in && (high_req_in || low_req_in))
		begin
			wait_r <= wait_r + 4'h1;
			if (wait_r == delay_in)
			begin
				entry_out <= 1'b1;
				busy_r <= 1'b1;
				wait_r <= 4'h0;
			end
		end
		// handler keeps its own context copy, so nothing is restored here
		else if (busy_r && return_cmd_in)
		begin
			return_out <= 1'b1;
			busy_r <= 1'b0;
		end
	end
endmodule : core_model

// ===== testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                   clock_in = 1'b0;
	logic                   reset_in, wr, rd, tick, accept, ret_cmd;
	logic [2:0]             addr;
	logic [7:0]             wdata, rdata;
	logic [3:0]             ext, port;
	irq_pkg::cause_events_t ev;
	logic                   entry, entry_low, ret, hreq, lreq, wake, full, empty;
	logic [20:0]            pc, top;
	irq_pkg::context_t      ctx, shadow;
	int                     miscompares, total_checks;

	irq_source_priority_logic i_dut (.clock_in(clock_in), .reset_in(reset_in), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .ext_irq_pins_in(ext),
		.port_upper_pins_in(port), .timer_tick_in(tick), .cause_events_in(ev),
		.irq_entry_in(entry), .irq_entry_low_in(entry_low), .irq_return_in(ret),
		.return_pc_in(pc), .context_in(ctx), .high_irq_req_out(hreq), .low_irq_req_out(lreq),
		.wake_out(wake), .stack_top_out(top), .stack_full_out(full), .stack_empty_out(empty),
		.shadow_out(shadow));
	core_model i_core (.clock_in(clock_in), .reset_in(reset_in), .high_req_in(hreq),
		.low_req_in(lreq), .accept_in(accept), .return_cmd_in(ret_cmd), .delay_in(4'h3),
		.entry_out(entry), .entry_low_out(entry_low), .return_out(ret), .pc_out(pc),
		.ctx_out(ctx));

	always #10 clock_in = ~clock_in;

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run

	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		total_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask : cyc

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock_in);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock_in);
		wr <= 1'b0;
		#1;
	endtask : wr_reg

	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clock_in);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock_in);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd_reg

	task automatic rd_chk(input string n, input logic [2:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd_reg(a, d);
		chk(n, e, d);
	endtask : rd_chk

	task automatic set_pin(input int i, input logic v);
		@(posedge clock_in);
		ext[i] <= v;
		cyc(6);
	endtask : set_pin

	task automatic t_regs();
		rd_chk("cause reset", 3'h0, irq_pkg::RC_RESET_VALUE);
		rd_chk("unmapped", 3'h7, 8'h00);
		wr_reg(3'h7, 8'hFF);
		wr_reg(3'h0, 8'hFF);
		rd_chk("cause written", 3'h0, 8'hDF);
		@(posedge clock_in);
		ev <= 6'h02;
		@(posedge clock_in);
		ev <= 6'h00;
		rd_chk("cause power on", 3'h0, 8'hDD);
		wr_reg(3'h0, 8'h00);
		rd_chk("cause cleared", 3'h0, 8'h0C);
		$display("test regs done");
	endtask : t_regs

	task automatic t_edges();
		logic [7:0] f;
		for (int i = 0; i < 4; i++)
			for (int s = 1; s >= 0; s--)
			begin
				wr_reg(3'h2, s ? (8'h40 >> i) : 8'h00);
				set_pin(i, s[0]);
				wr_reg(3'h1, 8'h00);
				wr_reg(3'h3, 8'h00);
				set_pin(i, !s[0]);
				rd_reg(i == 0 ? 3'h1 : 3'h3, f);
				chk("opposite edge", 0, (f >> (i == 0 ? 1 : i - 1)) & 8'h01);
				set_pin(i, s[0]);
				rd_reg(i == 0 ? 3'h1 : 3'h3, f);
				chk("edge flag", 1, (f >> (i == 0 ? 1 : i - 1)) & 8'h01);
				chk("wake disabled", 0, wake);
			end
		$display("test edges done");
	endtask : t_edges

	task automatic t_entry();
		logic [20:0]       p;
		irq_pkg::context_t c;
		int                n;
		wr_reg(3'h2, 8'h40);
		wr_reg(3'h1, 8'h10);
		set_pin(0, 1'b1);
		chk("wake", 1, wake);
		chk("high no global", 0, hreq);
		wr_reg(3'h1, 8'h92);
		chk("high global", 1, hreq);
		@(posedge clock_in);
		accept <= 1'b1;
		for (n = 0; n < 50 && entry !== 1'b1; n++)
			cyc(1);
		if (entry !== 1'b1)
		begin
			miscompares++;
			complete_run();
		end
		p = pc;
		c = ctx;
		cyc(1);
		accept <= 1'b0;
		chk("stack top", p, top);
		chk("shadow", c, shadow);
		chk("high after entry", 0, hreq);
		wr_reg(3'h1, 8'h10);
		@(posedge clock_in);
		ret_cmd <= 1'b1;
		@(posedge clock_in);
		ret_cmd <= 1'b0;
		cyc(2);
		rd_chk("first after return", 3'h1, 8'h90);
		chk("stack empty", 1, empty);
		set_pin(0, 1'b0);
		$display("test entry done");
	endtask : t_entry

	task automatic t_prio();
		wr_reg(3'h0, 8'h80);
		wr_reg(3'h6, 8'h01);
		wr_reg(3'h4, 8'hFE);
		wr_reg(3'h2, 8'h60);
		wr_reg(3'h1, 8'hE0);
		@(posedge clock_in);
		tick <= 1'b1;
		@(posedge clock_in);
		@(posedge clock_in);
		tick <= 1'b0;
		cyc(2);
		chk("timer low req", 1, lreq);
		rd_chk("timer high byte", 3'h5, 8'h00);
		wr_reg(3'h1, 8'hF4);
		set_pin(0, 1'b1);
		chk("ext0 high", 1, hreq);
		chk("low held off", 0, lreq);
		wr_reg(3'h1, 8'hC0);
		wr_reg(3'h3, 8'h48);
		set_pin(1, 1'b1);
		chk("ext1 high", 1, hreq);
		wr_reg(3'h3, 8'h09);
		chk("ext1 low", 1, lreq);
		wr_reg(3'h3, 8'h00);
		wr_reg(3'h6, 8'h03);
		wr_reg(3'h5, 8'hFF);
		wr_reg(3'h4, 8'hFF);
		wr_reg(3'h1, 8'hE0);
		@(posedge clock_in);
		tick <= 1'b1;
		@(posedge clock_in);
		tick <= 1'b0;
		cyc(2);
		chk("wide wrap req", 1, lreq);
		rd_chk("wide wrap low", 3'h4, 8'h00);
		wr_reg(3'h6, 8'h00);
		$display("test priority done");
	endtask : t_prio

	task automatic t_port();
		wr_reg(3'h1, 8'h88);
		wr_reg(3'h2, 8'h01);
		@(posedge clock_in);
		port[2] <= 1'b1;
		cyc(6);
		chk("change high req", 1, hreq);
		rd_chk("change flag", 3'h1, 8'h89);
		wr_reg(3'h1, 8'h80);
		@(posedge clock_in);
		port[2] <= 1'b0;
		cyc(6);
		rd_chk("fall flag", 3'h1, 8'h81);
		chk("change disabled", 0, wake);
		$display("test port done");
	endtask : t_port

	initial
	begin
		reset_in = 1'b1;
		{wr, rd, tick, accept, ret_cmd} = 5'h00;
		{addr, wdata, ext, port, ev} = '0;
		miscompares = 0;
		total_checks = 0;
		repeat (3) @(posedge clock_in);
		reset_in <= 1'b0;
		cyc(8);
		t_regs();
		t_edges();
		t_entry();
		t_prio();
		t_port();
		complete_run();
	end

	// no single scenario comes near this bound
	initial
	begin
		repeat (20000) @(posedge clock_in);
		miscompares++;
		complete_run();
	end
endmodule : testbench
